//--- inc/cantmc_pkg.sv
// Constants, types and state layout for the CAN transceiver mode control
package cantmc_pkg;
   // Clock rate in kHz
   localparam int          CLK_KHZ          = 25000;
   // Timing figures in microseconds
   localparam int          WAKE_FILTER_US   = 1;
   localparam int          WAKE_RX_DLY_US   = 1;
   localparam int          WAKE_REL_DLY_US  = 1;
   localparam int          DOM_TIMEOUT_US   = 1000;
   // Cycle counts derived from the rate
   localparam int          WAKE_FILTER_CYC  = WAKE_FILTER_US * CLK_KHZ / 1000;
   localparam int          WAKE_RX_DLY_CYC  = WAKE_RX_DLY_US * CLK_KHZ / 1000;
   localparam int          WAKE_REL_DLY_CYC = WAKE_REL_DLY_US * CLK_KHZ / 1000;
   localparam int          DOM_TIMEOUT_CYC  = DOM_TIMEOUT_US * CLK_KHZ / 1000;
   // Counter width and saturation value
   localparam int          CNT_W            = 16;
   localparam logic [15:0] CNT_ZERO         = 16'h0000;
   localparam logic [15:0] CNT_ONE          = 16'h0001;
   localparam logic [15:0] CNT_MAX          = 16'hFFFF;

   // Standby wake states
   typedef enum logic [2:0] {
      WK_IDLE,     // Bus recessive, no report
      WK_BLOCK,    // Initial dominant ignored until release
      WK_FILTER,   // Dominant being filtered
      WK_DELAY,    // Valid, waiting to report
      WK_ACTIVE,   // Receive held low
      WK_RELEASE   // Recessive, waiting to release
   } cantmc_wake_t;

   // State of the block apart from the output registers
   typedef struct packed {
      logic              txd_q;     // Previous transmit level
      logic              dom_off;   // Time-out transmitter disable
      logic [CNT_W-1:0]  dom_cnt;   // Dominant time-out counter
      logic              hot_off;   // Thermal transmitter disable
      cantmc_wake_t      wake;      // Wake state
      logic [CNT_W-1:0]  wake_cnt;  // Wake timing counter
      logic              stb_q;     // Previous mode
   } cantmc_state_t;

   // Pin-side outputs grouped
   typedef struct packed {
      logic drv_dom;    // Dominant driver on
      logic rxd;        // Receive output level
      logic split_oe;   // Split output enable
   } cantmc_out_t;
endpackage

//--- design/cantmc_top.sv
// Mode, wake, time-out and thermal control of the CAN transceiver
`timescale 1ns/1ps
module cantmc_top
   import cantmc_pkg::*;
#(
   parameter bit UNCOND_WAKE = 1'b1  // 1 unconditioned, 0 release-first
)
(
   // Clock and reset
   input  wire logic i_clock,
   input  wire logic i_srst,
   // Controller side
   input  wire logic i_transmit_in_n,   // Low requests dominant
   input  wire logic i_standby_select,  // High selects standby
   input  wire logic i_tx_floating,     // Transmit pin unconnected
   input  wire logic i_stb_floating,    // Standby pin unconnected
   output logic      o_receive_out,     // Receive data / wake report
   // Bus side
   input  wire logic i_bus_dominant,    // Normal receiver level
   input  wire logic i_lp_bus_dominant, // Low-power receiver level
   input  wire logic i_overtemp,        // Junction overtemperature
   output logic      o_drive_dominant,  // Dominant driver enable
   output logic      o_normal_rx_en,    // Normal receiver enable
   output logic      o_split_out,       // Split output level request
   output logic      o_split_oe         // Split output drive enable
);

   // State registers
   cantmc_state_t st_r;
   cantmc_state_t st_nxt;
   cantmc_out_t   out_r;
   cantmc_out_t   out_nxt;
   // Effective pin levels
   logic          txd;
   logic          stb;

   // Floating pins read high
   assign txd = i_transmit_in_n | i_tx_floating;
   assign stb = i_standby_select | i_stb_floating;

   // Next state and outputs
   always_comb
   begin
      st_nxt  = st_r;
      out_nxt = out_r;
      st_nxt.txd_q = txd;
      st_nxt.stb_q = stb;
      // Dominant time-out timer
      if (txd)
      begin
         st_nxt.dom_cnt = CNT_ZERO;
         st_nxt.dom_off = 1'b0;
      end
      else if (st_r.txd_q)
      begin
         st_nxt.dom_cnt = CNT_ONE;
      end
      else if (st_r.dom_cnt >= CNT_W'(DOM_TIMEOUT_CYC))
      begin
         st_nxt.dom_off = 1'b1;
      end
      else
      begin
         st_nxt.dom_cnt = st_r.dom_cnt + CNT_ONE;
      end
      // Thermal disable
      if (i_overtemp)
         st_nxt.hot_off = 1'b1;
      else if (txd)
         st_nxt.hot_off = 1'b0;
      // Wake detector, standby only
      if (!stb)
      begin
         st_nxt.wake     = WK_IDLE;
         st_nxt.wake_cnt = CNT_ZERO;
      end
      else if (!st_r.stb_q)
      begin
         // Standby entry, on a dominant bus or not
         st_nxt.wake_cnt = CNT_ZERO;
         if (i_lp_bus_dominant)
            st_nxt.wake = UNCOND_WAKE ? WK_ACTIVE : WK_BLOCK;
         else
            st_nxt.wake = WK_IDLE;
      end
      else
      begin
         if (st_r.wake_cnt != CNT_MAX)
            st_nxt.wake_cnt = st_r.wake_cnt + CNT_ONE;
         case (st_r.wake)
            WK_IDLE:
               if (i_lp_bus_dominant)
               begin
                  st_nxt.wake     = WK_FILTER;
                  st_nxt.wake_cnt = CNT_ONE;
               end
            WK_BLOCK:
               if (!i_lp_bus_dominant)
                  st_nxt.wake = WK_IDLE;
            WK_FILTER:
               if (!i_lp_bus_dominant)
                  st_nxt.wake = WK_IDLE;
               else if (st_r.wake_cnt >= CNT_W'(WAKE_FILTER_CYC))
               begin
                  st_nxt.wake     = WK_DELAY;
                  st_nxt.wake_cnt = CNT_ONE;
               end
            WK_DELAY:
               if (st_r.wake_cnt >= CNT_W'(WAKE_RX_DLY_CYC))
                  st_nxt.wake = WK_ACTIVE;
            WK_ACTIVE:
               if (!i_lp_bus_dominant)
               begin
                  st_nxt.wake     = WK_RELEASE;
                  st_nxt.wake_cnt = CNT_ONE;
               end
            WK_RELEASE:
               if (i_lp_bus_dominant)
                  st_nxt.wake = WK_ACTIVE;
               else if (st_r.wake_cnt >= CNT_W'(WAKE_REL_DLY_CYC))
                  st_nxt.wake = WK_IDLE;
            default:
               st_nxt.wake = WK_IDLE;
         endcase
      end
      // Outputs from next state
      if (stb)
      begin
         out_nxt.drv_dom  = 1'b0;
         out_nxt.split_oe = 1'b0;
         out_nxt.rxd      = !(st_nxt.wake == WK_ACTIVE ||
                              st_nxt.wake == WK_RELEASE);
      end
      else
      begin
         out_nxt.drv_dom  = !txd && !st_nxt.dom_off &&
                            !st_nxt.hot_off;
         out_nxt.split_oe = 1'b1;
         out_nxt.rxd      = !i_bus_dominant;
      end
   end

   // Register the state
   always_ff @(posedge i_clock)
   begin
      if (i_srst)
      begin
         st_r  <= '{txd_q: 1'b1, dom_off: 1'b0, dom_cnt: CNT_ZERO,
                    hot_off: 1'b0, wake: WK_IDLE, wake_cnt: CNT_ZERO,
                    stb_q: 1'b1};
         out_r <= '{drv_dom: 1'b0, rxd: 1'b1, split_oe: 1'b0};
      end
      else
      begin
         st_r  <= st_nxt;
         out_r <= out_nxt;
      end
   end

   // Pin outputs
   assign o_receive_out    = out_r.rxd;
   assign o_drive_dominant = out_r.drv_dom;
   assign o_split_oe       = out_r.split_oe;
   assign o_split_out      = 1'b1;
   assign o_normal_rx_en   = !st_r.stb_q;

   // Standby never drives the bus
   property p_stby_quiet;
      @(posedge i_clock) disable iff (i_srst)
      st_r.stb_q |-> !o_drive_dominant && !o_split_oe;
   endproperty
   a_stby_quiet: assert property (p_stby_quiet)
      else $error("bus driven in standby");

   // Normal mode receive follows bus
   property p_rx_follow;
      @(posedge i_clock) disable iff (i_srst)
      !stb ##1 !st_r.stb_q |-> o_receive_out == !$past(i_bus_dominant);
   endproperty
   a_rx_follow: assert property (p_rx_follow)
      else $error("receive does not follow bus");

   // Transmit low drives dominant when healthy
   property p_tx_dom;
      @(posedge i_clock) disable iff (i_srst)
      !stb && !txd && !st_nxt.dom_off && !i_overtemp && !st_r.hot_off
      |=> o_drive_dominant;
   endproperty
   a_tx_dom: assert property (p_tx_dom)
      else $error("dominant not driven");

   // Overtemperature stops the driver
   property p_hot;
      @(posedge i_clock) disable iff (i_srst)
      i_overtemp |=> !o_drive_dominant;
   endproperty
   a_hot: assert property (p_hot)
      else $error("driver on while hot");

   // Thermal off holds while transmit low
   property p_hot_hold;
      @(posedge i_clock) disable iff (i_srst)
      st_r.hot_off && !txd |=> st_r.hot_off;
   endproperty
   a_hot_hold: assert property (p_hot_hold)
      else $error("thermal off cleared early");

   // Time-out fires on long low
   property p_timeout;
      @(posedge i_clock) disable iff (i_srst)
      st_r.dom_cnt >= CNT_W'(DOM_TIMEOUT_CYC) && !txd && !st_r.txd_q
      |=> st_r.dom_off;
   endproperty
   a_timeout: assert property (p_timeout)
      else $error("time-out did not fire");

   // Falling edge starts timer
   property p_fall;
      @(posedge i_clock) disable iff (i_srst)
      $fell(txd) |-> st_r.txd_q ##1 st_r.dom_cnt == CNT_ONE;
   endproperty
   a_fall: assert property (p_fall)
      else $error("timer not started");

   // Rising edge clears disable
   property p_rise;
      @(posedge i_clock) disable iff (i_srst)
      txd |=> !st_r.dom_off && st_r.dom_cnt == CNT_ZERO;
   endproperty
   a_rise: assert property (p_rise)
      else $error("time-out not cleared");

   // Split enable tracks mode
   property p_split;
      @(posedge i_clock) disable iff (i_srst)
      !stb |=> o_split_oe;
   endproperty
   a_split: assert property (p_split)
      else $error("split not enabled");

   // Wake report only in active states
   property p_wake_rx;
      @(posedge i_clock) disable iff (i_srst)
      stb && st_r.stb_q && st_r.wake == WK_IDLE && !i_lp_bus_dominant
      |=> o_receive_out;
   endproperty
   a_wake_rx: assert property (p_wake_rx)
      else $error("wake report held");

endmodule // cantmc_top

//--- bench/cantmc_ctrl_model.sv
// Protocol controller model driving transmit and mode pins
`timescale 1ns/1ps
module cantmc_ctrl_model
(
   // Clock
   input  wire logic i_clock,
   // Controller pins
   output logic      o_tx_n,
   output logic      o_stb
);
   // Recessive, standby at start
   initial
   begin
      o_tx_n = 1'b1;
      o_stb  = 1'b1;
   end
   // One bit, held 25..625 cycles (1 Mbps..40 kbps)
   task automatic send_bit(input logic v, input int n);
      int k;
      k = (n < 25) ? 25 : ((n > 625) ? 625 : n);
      @(posedge i_clock) o_tx_n <= v;
      repeat (k - 1) @(posedge i_clock);
   endtask
   // Stuck-low fault, only when a test asks
   task automatic stuck_low(input int n);
      @(posedge i_clock) o_tx_n <= 1'b0;
      repeat (n - 1) @(posedge i_clock);
   endtask
   // Mode pin
   task automatic set_mode(input logic s);
      @(posedge i_clock) o_stb <= s;
   endtask
endmodule // cantmc_ctrl_model

//--- bench/cantmc_top_test.sv
// Self-checking bench of the transceiver mode control
`timescale 1ns/1ps
module cantmc_top_test;
   logic i_clock = 1'b0;   // 25 MHz clock
   logic i_srst  = 1'b1;   // Sync reset
   logic txf = 1'b0;       // Transmit pin open
   logic stbf = 1'b0;      // Mode pin open
   logic bus = 1'b0;       // Bus dominant
   logic ot = 1'b0;        // Overtemperature
   logic tx_n, stb, rx, rx2, drv, nrx, spo, soe;
   logic drv2, nrx2, spo2, soe2; // Release-first variant outputs
   int   checks = 0;
   int   mismatches = 0;
   // Controller model
   cantmc_ctrl_model i_cantmc_ctrl_model (.i_clock(i_clock),
      .o_tx_n(tx_n), .o_stb(stb));
   // Unconditioned wake variant
   cantmc_top #(.UNCOND_WAKE(1'b1)) i_cantmc_top (.i_clock(i_clock),
      .i_srst(i_srst), .i_transmit_in_n(tx_n), .i_standby_select(stb),
      .i_tx_floating(txf), .i_stb_floating(stbf), .o_receive_out(rx),
      .i_bus_dominant(bus), .i_lp_bus_dominant(bus), .i_overtemp(ot),
      .o_drive_dominant(drv), .o_normal_rx_en(nrx), .o_split_out(spo),
      .o_split_oe(soe));
   // Release-first variant, all outputs watched
   cantmc_top #(.UNCOND_WAKE(1'b0)) i_cantmc_top_rf (.i_clock(i_clock),
      .i_srst(i_srst), .i_transmit_in_n(tx_n), .i_standby_select(stb),
      .i_tx_floating(txf), .i_stb_floating(stbf), .o_receive_out(rx2),
      .i_bus_dominant(bus), .i_lp_bus_dominant(bus), .i_overtemp(ot),
      .o_drive_dominant(drv2), .o_normal_rx_en(nrx2), .o_split_out(spo2),
      .o_split_oe(soe2));
   // Clock
   initial
   begin
      forever #20 i_clock = ~i_clock;
   end
   // Wait cycles, then settle
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask
   // Compare one bit
   task automatic chk(input string nm, input logic e, input logic g);
      checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("BAD %s exp %b got %b", nm, e, g);
      end
   endtask
   // Counts and verdict
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Normal mode transmit and receive
   task automatic t_normal;
      i_cantmc_ctrl_model.set_mode(1'b0);
      cyc(2);
      chk("nrx", 1'b1, nrx);
      chk("soe", 1'b1, soe);
      chk("spo", 1'b1, spo);
      chk("nrx2", 1'b1, nrx2);
      chk("soe2", 1'b1, soe2);
      i_cantmc_ctrl_model.send_bit(1'b0, 25);
      #1 chk("drv", 1'b1, drv);
      chk("drv2", 1'b1, drv2);
      @(posedge i_clock) bus <= 1'b1;
      cyc(2);
      chk("rx", 1'b0, rx);
      @(posedge i_clock) bus <= 1'b0;
      cyc(2);
      chk("rx", 1'b1, rx);
      i_cantmc_ctrl_model.send_bit(1'b1, 25);
      #1 chk("drv", 1'b0, drv);
   endtask
   // Stuck transmit time-out and edge clear
   task automatic t_timeout;
      i_cantmc_ctrl_model.stuck_low(24990);
      #1 chk("drv", 1'b1, drv);
      cyc(30);
      chk("drv", 1'b0, drv);
      i_cantmc_ctrl_model.send_bit(1'b1, 25);
      i_cantmc_ctrl_model.send_bit(1'b0, 25);
      #1 chk("drv", 1'b1, drv);
      i_cantmc_ctrl_model.send_bit(1'b1, 25);
   endtask
   // Thermal shutdown and its release
   task automatic t_thermal;
      @(posedge i_clock) ot <= 1'b1;
      bus <= 1'b1;
      i_cantmc_ctrl_model.send_bit(1'b0, 25);
      #1 chk("drv", 1'b0, drv);
      chk("rx", 1'b0, rx);
      @(posedge i_clock) ot <= 1'b0;
      bus <= 1'b0;
      cyc(3);
      chk("drv", 1'b0, drv);
      i_cantmc_ctrl_model.send_bit(1'b1, 25);
      i_cantmc_ctrl_model.send_bit(1'b0, 25);
      #1 chk("drv", 1'b1, drv);
      i_cantmc_ctrl_model.send_bit(1'b1, 25);
   endtask
   // Open pins read high
   task automatic t_float;
      @(posedge i_clock) txf <= 1'b1;
      i_cantmc_ctrl_model.send_bit(1'b0, 25);
      #1 chk("drv", 1'b0, drv);
      i_cantmc_ctrl_model.send_bit(1'b1, 25);
      @(posedge i_clock) txf <= 1'b0;
      stbf <= 1'b1;
      cyc(2);
      chk("nrx", 1'b0, nrx);
      @(posedge i_clock) stbf <= 1'b0;
   endtask
   // Standby keeps the driver off, filters and reports wake
   task automatic t_standby;
      i_cantmc_ctrl_model.set_mode(1'b1);
      i_cantmc_ctrl_model.send_bit(1'b0, 25);
      #1 chk("drv", 1'b0, drv);
      chk("nrx", 1'b0, nrx);
      chk("soe", 1'b0, soe);
      i_cantmc_ctrl_model.send_bit(1'b1, 25);
      @(posedge i_clock) bus <= 1'b1;
      repeat (10) @(posedge i_clock);
      bus <= 1'b0;
      cyc(80);
      chk("rx", 1'b1, rx);
      @(posedge i_clock) bus <= 1'b1;
      cyc(45);
      chk("rx", 1'b1, rx);
      cyc(12);
      chk("rx", 1'b0, rx);
      @(posedge i_clock) bus <= 1'b0;
      cyc(20);
      chk("rx", 1'b0, rx);
      cyc(10);
      chk("rx", 1'b1, rx);
   endtask
   // Standby entry on a standing dominant
   task automatic t_entry;
      i_cantmc_ctrl_model.set_mode(1'b0);
      @(posedge i_clock) bus <= 1'b1;
      i_cantmc_ctrl_model.set_mode(1'b1);
      cyc(3);
      chk("rx", 1'b0, rx);
      chk("drv2", 1'b0, drv2);
      chk("nrx2", 1'b0, nrx2);
      chk("soe2", 1'b0, soe2);
      chk("spo2", 1'b1, spo2);
      cyc(100);
      chk("rx2", 1'b1, rx2);
      @(posedge i_clock) bus <= 1'b0;
      cyc(40);
      @(posedge i_clock) bus <= 1'b1;
      cyc(60);
      chk("rx2", 1'b0, rx2);
      chk("rx", 1'b0, rx);
      @(posedge i_clock) bus <= 1'b0;
      // Dominant again inside the release delay keeps the report
      cyc(10);
      @(posedge i_clock) bus <= 1'b1;
      cyc(30);
      chk("rx", 1'b0, rx);
      @(posedge i_clock) bus <= 1'b0;
   endtask
   // Main sequence
   initial
   begin
      cyc(4);
      chk("rx", 1'b1, rx);
      chk("drv", 1'b0, drv);
      chk("soe", 1'b0, soe);
      @(posedge i_clock) i_srst <= 1'b0;
      t_normal();
      t_timeout();
      t_thermal();
      t_float();
      t_standby();
      t_entry();
      complete_run();
   end
   // Hang guard
   initial
   begin
      repeat (40000) @(posedge i_clock);
      mismatches++;
      complete_run();
   end
endmodule // cantmc_top_test
